// ---- common/dcl_defs.svh ----
// Timing and reset constants for the dual CAN bus logic unit.
`ifndef DCL_DEFS_SVH
`define DCL_DEFS_SVH
`define DCL_TDOM_CYCLES      20'd100000
`define DCL_SUPP_CYCLES      8'd20
`define DCL_SHORT_CYCLES     16'd1000
`define DCL_LVL_RECESSIVE    1'b1
`define DCL_LVL_DOMINANT     1'b0
`define DCL_SYNC_RESET       2'b11
`endif

// ---- common/dcl_pkg.sv ----
// Types shared by the dual CAN bus logic unit.
`default_nettype none
package dcl_pkg;
    typedef struct packed {
        logic local_tx;
        logic exp_tx;
        logic rx1;
        logic rx2;
    } dcl_sig_s;
endpackage : dcl_pkg
`default_nettype wire

// ---- dv/dcl_bus_model.sv ----
// Wired-dominant model of both buses with one further node on each.
`default_nettype none
module dcl_bus_model (
    input  wire logic drive1,
    input  wire logic drive2,
    input  wire logic ext1_dom,
    input  wire logic ext2_dom,
    output logic      comp1,
    output logic      comp2
);
    timeunit 1ns;
    timeprecision 1ps;
    assign comp1 = ~(drive1 | ext1_dom);
    assign comp2 = ~(drive2 | ext2_dom);
endmodule : dcl_bus_model
`default_nettype wire

// ---- dv/dcl_logic_unit_tb.sv ----
// Self-checking bench for the dual CAN bus logic unit.
`default_nettype none
module dcl_logic_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic   clk = 1'b0, rst = 1'b1, por = 1'b1, tx = 1'b1, text = 1'b1;
    logic   en1 = 1'b0, en2 = 1'b0, ot = 1'b0, sh1 = 1'b0, sh2 = 1'b0;
    logic   e1 = 1'b0, e2 = 1'b0;
    logic   c1, c2, d1, d2, rx0, rx0_oe, rint, rint_oe;
    logic   [3:0] v;
    integer seed = 32'hb2e1;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer i;
    always #5 clk = ~clk;
    dcl_bus_model bus (.drive1(d1), .drive2(d2), .ext1_dom(e1), .ext2_dom(e2),
        .comp1(c1), .comp2(c2));
    dcl_logic_unit #(.TDOM_CYCLES(20'd50), .SUPP_CYCLES(8'd20), .SHORT_CYCLES(16'd10)) dut (
        .clk(clk), .rst(rst), .por(por), .local_tx_in(tx), .exp_tx_in(text),
        .bus1_enable_n(en1), .bus2_enable_n(en2), .bus1_comp(c1), .bus2_comp(c2),
        .over_temp(ot), .low_line_battery_short_detect1(sh1),
        .low_line_battery_short_detect2(sh2), .bus1_drive(d1), .bus2_drive(d2),
        .local_rx_out(rx0), .local_rx_oe(rx0_oe), .exp_rx_out(rint), .exp_rx_oe(rint_oe));
    task end_of_test;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Outputs {bus1 drive, bus2 drive, local rx, expansion rx} for inputs {en1,en2,tx,text}.
    function automatic logic [3:0] expect_of(input logic [3:0] u, input logic b1, b2, t);
        logic r1, r2, dt;
        r1 = b1 & ~u[3];
        r2 = b2 & ~u[2];
        dt = ~u[1] | ~u[0];
        return {~u[3] & ~t & (dt | (r2 & ~r1)), ~u[2] & ~t & (dt | (r1 & ~r2)), ~(dt | r1 | r2),
            ~(~u[1] | r1 | r2)};
    endfunction : expect_of
    task put(input logic [3:0] u, input logic b1, b2, t);
        @(negedge clk);
        {en1, en2, tx, text, e1, e2, ot} = {u, b1, b2, t};
        repeat (8) @(negedge clk);
        chk({d1, d2, rx0, rint}, expect_of(u, b1, b2, t));
        {tx, text, e1, e2, ot} = 5'h18;
        repeat (25) @(negedge clk);
    endtask : put
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            miscompares++;
            end_of_test();
        end
    end
    initial
    begin
        repeat (12) @(negedge clk);
        chk({d1, d2, rx0, rint_oe}, 4'h2);
        chk({2'b00, rx0_oe, rint_oe}, 4'h2);
        {rst, por} = 2'b00;
        repeat (5) @(negedge clk);
        chk({d1, d2, rx0, rint}, 4'h3);
        chk({2'b00, rx0_oe, rint_oe}, 4'h3);
        for (i = 0; i < 16; i++) put(i[3:0], 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 4; i++) put({i[1:0], 2'b11}, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 4; i++) put({i[1:0], 2'b11}, 1'b0, 1'b1, 1'b0);
        for (i = 0; i < 40; i++)
        begin
            v = 4'($random(seed));
            put(v, v[1] & v[0] & i[0], v[1] & v[0] & i[1], i[2] & i[3]);
        end
        tx = 1'b0;
        repeat (8) @(negedge clk);
        chk({d1, d2, rx0, rint}, 4'hc);
        repeat (60) @(negedge clk);
        chk({d1, d2, rx0, rint}, 4'h3);
        tx = 1'b1;
        repeat (25) @(negedge clk);
        for (i = 1; i < 3; i++)
        begin
            {sh1, sh2} = i[1:0];
            tx = 1'b0;
            repeat (20) @(negedge clk);
            chk({d1, d2, rx0, rint}, {i[0], i[1], 2'b00});
            {tx, sh1, sh2} = 3'b100;
            repeat (25) @(negedge clk);
        end
        {tx, por} = 2'b01;
        repeat (3) @(negedge clk);
        chk({d1, d2, rx0, rint_oe}, 4'h2);
        {tx, por} = 2'b10;
        repeat (5) @(negedge clk);
        end_of_test();
    end
endmodule : dcl_logic_unit_tb
`default_nettype wire

// ---- verilog/dcl_logic_unit.sv ----
// Logic unit of a dual-bus CAN transceiver with repeater and feedback suppression.
`default_nettype none
`include "dcl_defs.svh"
module dcl_logic_unit #(
    parameter logic [19:0] TDOM_CYCLES  = `DCL_TDOM_CYCLES,
    parameter logic [7:0]  SUPP_CYCLES  = `DCL_SUPP_CYCLES,
    parameter logic [15:0] SHORT_CYCLES = `DCL_SHORT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic por,
    input  wire logic local_tx_in,
    input  wire logic exp_tx_in,
    input  wire logic bus1_enable_n,
    input  wire logic bus2_enable_n,
    input  wire logic bus1_comp,
    input  wire logic bus2_comp,
    input  wire logic over_temp,
    input  wire logic low_line_battery_short_detect1,
    input  wire logic low_line_battery_short_detect2,
    output logic      bus1_drive,
    output logic      bus2_drive,
    output logic      local_rx_out,
    output logic      local_rx_oe,
    output logic      exp_rx_out,
    output logic      exp_rx_oe
);
    dcl_pkg::dcl_sig_s sync1;
    dcl_pkg::dcl_sig_s sync2;
    dcl_pkg::dcl_sig_s timed;
    logic [1:0]        en1_sync;
    logic [1:0]        en2_sync;
    logic [1:0]        ot_sync;
    logic [1:0]        sh1_sync;
    logic [1:0]        sh2_sync;
    logic              hold;
    logic              rx1_gated;
    logic              rx2_gated;
    logic              rx1_eff;
    logic              rx2_eff;
    logic              tx_any;
    logic              want1;
    logic              want2;
    logic [7:0]        supp1;
    logic [7:0]        supp2;
    logic [15:0]       sh1_cnt;
    logic [15:0]       sh2_cnt;
    logic              sh1_off;
    logic              sh2_off;
    logic              next_local_rx;
    logic              next_exp_rx;

    // Reception on a bus is blanked while we drive it and while its window runs.
    function automatic logic rx_masked(
        input logic       rx,
        input logic       drive,
        input logic [7:0] window
    );
        return rx | drive | (window != 8'h0);
    endfunction : rx_masked

    // A transmitter may work only while enabled, cool and not shorted.
    function automatic logic drive_ok(
        input logic enable_n,
        input logic hot,
        input logic shorted
    );
        return !enable_n & !hot & !shorted;
    endfunction : drive_ok

    // Relay into a bus only while that bus carries no foreign dominant of its own,
    // so that two buses going dominant together cannot lock each other on.
    function automatic logic relay_in(
        input logic other_rx,
        input logic own_rx
    );
        return (other_rx == `DCL_LVL_DOMINANT) & (own_rx != `DCL_LVL_DOMINANT);
    endfunction : relay_in

    assign hold = rst | por;

    // Inputs come from pins; synchronisers reset to recessive and disabled.
    always_ff @(posedge clk)
    begin
        if (hold)
        begin
            sync1 <= '1;
            sync2 <= '1;
        end
        else
        begin
            sync1 <= '{local_tx_in, exp_tx_in, bus1_comp, bus2_comp};
            sync2 <= sync1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (hold)
        begin
            en1_sync <= `DCL_SYNC_RESET;
            en2_sync <= `DCL_SYNC_RESET;
            ot_sync  <= 2'h0;
            sh1_sync <= 2'h0;
            sh2_sync <= 2'h0;
        end
        else
        begin
            en1_sync <= {en1_sync[0], bus1_enable_n};
            en2_sync <= {en2_sync[0], bus2_enable_n};
            ot_sync  <= {ot_sync[0], over_temp};
            sh1_sync <= {sh1_sync[0], low_line_battery_short_detect1};
            sh2_sync <= {sh2_sync[0], low_line_battery_short_detect2};
        end
    end

    // Gate each comparator by its enable before the timers.
    assign rx1_gated = en1_sync[1] | sync2.rx1;
    assign rx2_gated = en2_sync[1] | sync2.rx2;

    dcl_timer #(.TDOM(TDOM_CYCLES)) u_t_ltx (
        .clk(clk), .rst(hold), .din(sync2.local_tx), .dout(timed.local_tx));
    dcl_timer #(.TDOM(TDOM_CYCLES)) u_t_etx (
        .clk(clk), .rst(hold), .din(sync2.exp_tx), .dout(timed.exp_tx));
    dcl_timer #(.TDOM(TDOM_CYCLES)) u_t_rx1 (
        .clk(clk), .rst(hold), .din(rx1_gated), .dout(timed.rx1));
    dcl_timer #(.TDOM(TDOM_CYCLES)) u_t_rx2 (
        .clk(clk), .rst(hold), .din(rx2_gated), .dout(timed.rx2));

    // Reception on a bus is masked while driven and for a delay after.
    assign rx1_eff = rx_masked(timed.rx1, bus1_drive, supp1);
    assign rx2_eff = rx_masked(timed.rx2, bus2_drive, supp2);

    always_ff @(posedge clk)
    begin
        if (hold)
            supp1 <= 8'h0;
        else if (bus1_drive)
            supp1 <= SUPP_CYCLES;
        else if (supp1 != 8'h0)
            supp1 <= supp1 - 8'h1;
    end

    always_ff @(posedge clk)
    begin
        if (hold)
            supp2 <= 8'h0;
        else if (bus2_drive)
            supp2 <= SUPP_CYCLES;
        else if (supp2 != 8'h0)
            supp2 <= supp2 - 8'h1;
    end

    // Debounce of a low-line short to battery, per bus.
    always_ff @(posedge clk)
    begin
        if (hold || !sh1_sync[1])
            sh1_cnt <= 16'h0;
        else if (sh1_cnt != SHORT_CYCLES)
            sh1_cnt <= sh1_cnt + 16'h1;
    end

    always_ff @(posedge clk)
    begin
        if (hold || !sh2_sync[1])
            sh2_cnt <= 16'h0;
        else if (sh2_cnt != SHORT_CYCLES)
            sh2_cnt <= sh2_cnt + 16'h1;
    end

    assign sh1_off = (sh1_cnt == SHORT_CYCLES);
    assign sh2_off = (sh2_cnt == SHORT_CYCLES);

    // Dominant from either transmit input or the other bus, relayed symmetrically.
    assign tx_any = (timed.local_tx == `DCL_LVL_DOMINANT)
                  | (timed.exp_tx == `DCL_LVL_DOMINANT);
    assign want1  = tx_any | relay_in(rx2_eff, rx1_eff);
    assign want2  = tx_any | relay_in(rx1_eff, rx2_eff);

    // Transmitters are active only for dominant and only when nothing forbids it.
    always_ff @(posedge clk)
    begin
        if (hold)
        begin
            bus1_drive <= 1'b0;
            bus2_drive <= 1'b0;
        end
        else
        begin
            bus1_drive <= want1
                        & drive_ok(en1_sync[1], ot_sync[1], sh1_off);
            bus2_drive <= want2
                        & drive_ok(en2_sync[1], ot_sync[1], sh2_off);
        end
    end

    // Receive outputs: bus reception reaches both, expansion input only local.
    always_comb
    begin
        next_local_rx = timed.local_tx & timed.exp_tx & rx1_eff & rx2_eff;
        next_exp_rx   = timed.local_tx & rx1_eff & rx2_eff;
    end

    always_ff @(posedge clk)
    begin
        if (hold)
        begin
            local_rx_out <= `DCL_LVL_RECESSIVE;
            exp_rx_out   <= `DCL_LVL_RECESSIVE;
            local_rx_oe  <= 1'b1;
            exp_rx_oe    <= 1'b0;
        end
        else
        begin
            local_rx_out <= next_local_rx;
            exp_rx_out   <= next_exp_rx;
            local_rx_oe  <= 1'b1;
            exp_rx_oe    <= 1'b1;
        end
    end

    // Bus state is wired-AND: drivers never force recessive.

    a_drive_enable: assert property (@(posedge clk) disable iff (hold)
        en1_sync[1] |=> !bus1_drive)
        else $error("bus1 driven while disabled");
    a_drive2_enable: assert property (@(posedge clk) disable iff (hold)
        en2_sync[1] |=> !bus2_drive)
        else $error("bus2 driven while disabled");
    a_rx1_disabled: assert property (@(posedge clk) disable iff (hold)
        en1_sync[1] |-> rx1_gated)
        else $error("bus1 receive not gated");
    a_rx2_disabled: assert property (@(posedge clk) disable iff (hold)
        en2_sync[1] |-> rx2_gated)
        else $error("bus2 receive not gated");
    a_rx1_enabled: assert property (@(posedge clk) disable iff (hold)
        !en1_sync[1] |-> (rx1_gated == sync2.rx1))
        else $error("bus1 receive altered");
    a_rx2_enabled: assert property (@(posedge clk) disable iff (hold)
        !en2_sync[1] |-> (rx2_gated == sync2.rx2))
        else $error("bus2 receive altered");

    // A timer can only turn dominant into recessive, never the reverse.
    a_ltx_timer: assert property (@(posedge clk) disable iff (hold)
        !timed.local_tx |-> !sync2.local_tx)
        else $error("local tx timer made dominant");
    a_etx_timer: assert property (@(posedge clk) disable iff (hold)
        !timed.exp_tx |-> !sync2.exp_tx)
        else $error("expansion tx timer made dominant");
    a_rx1_timer: assert property (@(posedge clk) disable iff (hold)
        !timed.rx1 |-> !rx1_gated)
        else $error("bus1 timer made dominant");
    a_rx2_timer: assert property (@(posedge clk) disable iff (hold)
        !timed.rx2 |-> !rx2_gated)
        else $error("bus2 timer made dominant");

    a_thermal_off: assert property (@(posedge clk) disable iff (hold)
        ot_sync[1] |=> !bus1_drive && !bus2_drive)
        else $error("driven in over-temperature");
    a_thermal_rx: assert property (@(posedge clk) disable iff (hold)
        (ot_sync[1] && !rx1_eff) |=> !local_rx_out)
        else $error("reception lost in over-temperature");
    a_local_rx_tx: assert property (@(posedge clk) disable iff (hold)
        !timed.local_tx |=> !local_rx_out && !exp_rx_out)
        else $error("local tx lost");
    a_exp_no_loop: assert property (@(posedge clk) disable iff (hold)
        (timed.local_tx && rx1_eff && rx2_eff) |=> exp_rx_out)
        else $error("expansion loop");
    a_exp_tx_local: assert property (@(posedge clk) disable iff (hold)
        !timed.exp_tx |=> !local_rx_out)
        else $error("expansion tx lost");
    a_bus_rx_out: assert property (@(posedge clk) disable iff (hold)
        !rx1_eff |=> !local_rx_out && !exp_rx_out)
        else $error("bus1 reception lost");

    a_tx_to_bus: assert property (@(posedge clk) disable iff (hold)
        (tx_any && !en2_sync[1] && !ot_sync[1] && !sh2_off) |=> bus2_drive)
        else $error("bus2 not driven");
    a_tx_to_bus1: assert property (@(posedge clk) disable iff (hold)
        (tx_any && !en1_sync[1] && !ot_sync[1] && !sh1_off) |=> bus1_drive)
        else $error("bus1 not driven");
    a_relay_bus2: assert property (@(posedge clk) disable iff (hold)
        relay_in(rx1_eff, rx2_eff) && !en2_sync[1] && !ot_sync[1] && !sh2_off |=> bus2_drive)
        else $error("bus1 not relayed");
    a_relay_bus1: assert property (@(posedge clk) disable iff (hold)
        relay_in(rx2_eff, rx1_eff) && !en1_sync[1] && !ot_sync[1] && !sh1_off |=> bus1_drive)
        else $error("bus2 not relayed");

    // The blanking window covers the echo of our own dominant.
    a_suppress_hold: assert property (@(posedge clk) disable iff (hold)
        $fell(bus1_drive) |-> rx1_eff)
        else $error("bus1 echo not masked");
    a_suppress_hold2: assert property (@(posedge clk) disable iff (hold)
        $fell(bus2_drive) |-> rx2_eff)
        else $error("bus2 echo not masked");
    a_mask_window: assert property (@(posedge clk) disable iff (hold)
        (supp1 != 8'h0) |-> rx1_eff)
        else $error("bus1 window not masked");
    a_passive_recv: assert property (@(posedge clk) disable iff (hold)
        !want1 |=> !bus1_drive)
        else $error("bus1 active on recessive");
    a_passive_bus2: assert property (@(posedge clk) disable iff (hold)
        !want2 |=> !bus2_drive)
        else $error("bus2 active on recessive");
    a_short_off: assert property (@(posedge clk) disable iff (hold)
        sh2_off |=> !bus2_drive)
        else $error("shorted bus2 driven");
    a_short1_off: assert property (@(posedge clk) disable iff (hold)
        sh1_off |=> !bus1_drive)
        else $error("shorted bus1 driven");

    a_oe_release: assert property (@(posedge clk) disable iff (hold)
        1'b1 |=> local_rx_oe && exp_rx_oe)
        else $error("receive outputs not enabled");
    a_por_state: assert property (@(posedge clk)
        hold |=> local_rx_out && local_rx_oe && !bus1_drive && !bus2_drive && !exp_rx_oe)
        else $error("reset state wrong");
    a_por_exp_rx: assert property (@(posedge clk)
        hold |=> exp_rx_out)
        else $error("expansion output not recessive in reset");
endmodule : dcl_logic_unit
`default_nettype wire

// ---- verilog/dcl_timer.sv ----
// Dominant time-out timer: passes its input until it stays dominant too long.
`default_nettype none
`include "dcl_defs.svh"
module dcl_timer #(
    parameter logic [19:0] TDOM = `DCL_TDOM_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic [19:0] count;

    always_ff @(posedge clk)
    begin
        if (rst || din == `DCL_LVL_RECESSIVE)
            count <= 20'h0;
        else if (count != TDOM)
            count <= count + 20'h1;
    end

    // The output is forced recessive once the dominant run reaches the limit.
    always_comb
    begin
        dout = din | (count == TDOM);
    end
endmodule : dcl_timer
`default_nettype wire
